// [ced_pkg.sv]
// Shared constants, tables and types for the exception dispatch unit
package ced_pkg;

  // ==========================================================
  // Exception sources, index equals priority order
  localparam int NSRC = 18;
  localparam int SW = 5;
  localparam int S_MCD = 0;
  localparam int S_IAC = 1;
  localparam int S_MCI = 2;
  localparam int S_EDU = 3;
  localparam int S_CIN = 4;
  localparam int S_WDT = 5;
  localparam int S_ITLB = 6;
  localparam int S_ISNA = 7;
  localparam int S_ISNX = 8;
  localparam int S_PROG = 9;
  localparam int S_SC = 10;
  localparam int S_DTLB = 11;
  localparam int S_DSI = 12;
  localparam int S_ALGN = 13;
  localparam int S_DBGL = 14;
  localparam int S_EXT = 15;
  localparam int S_FIT = 16;
  localparam int S_PIT = 17;

  // ==========================================================
  // Per-source class masks
  localparam logic [NSRC-1:0] CRIT_MASK = 18'h0403F;
  localparam logic [NSRC-1:0] ESR_MASK = 18'h01B85;
  localparam logic [NSRC-1:0] DATA_FAULT_ADDRESS_REG_MASK = 18'h03800;
  localparam logic [NSRC-1:0] NEXT_MASK = 18'h00400;
  localparam logic [NSRC-1:0] ME_MASK = 18'h00005;
  localparam logic [NSRC-1:0] DE_MASK = 18'h0400A;
  localparam logic [NSRC-1:0] CE_MASK = 18'h00030;
  localparam logic [NSRC-1:0] EE_MASK = 18'h38000;

  // ==========================================================
  // Machine state fields
  localparam int MSR_CE = 17;
  localparam int MSR_EE = 15;
  localparam int MSR_PR = 14;
  localparam int MSR_ME = 12;
  localparam int MSR_DE = 9;
  localparam logic [31:0] MSR_RST = 32'h00000000;
  localparam logic [31:0] MSR_CLR_ALL = 32'h0000C030;
  localparam logic [31:0] MSR_CLR_CRIT = 32'h00020200;
  localparam logic [31:0] MSR_CLR_MCHK = 32'h00001000;
  localparam logic [31:0] ESR_PPR = 32'h08000000;
  localparam logic [31:0] VPB_MASK = 32'hFFFF0000;
  localparam logic [31:0] REG_RST = 32'h00000000;

  // ==========================================================
  // Register map and bus answers
  localparam logic [7:0] A_MSR = 8'h00;
  localparam logic [7:0] A_VPB = 8'h04;
  localparam logic [7:0] A_NRA = 8'h08;
  localparam logic [7:0] A_NSS = 8'h0C;
  localparam logic [7:0] A_CRA = 8'h10;
  localparam logic [7:0] A_CSS = 8'h14;
  localparam logic [7:0] A_ESR = 8'h18;
  localparam logic [7:0] A_DFA = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum {ST_IDLE, ST_SYNC, ST_RWAIT} ced_state_t;

  typedef struct packed {
    logic [NSRC-1:0] req;
    logic [31:0] cur_pc;
    logic [31:0] next_pc;
    logic [31:0] syndrome;
    logic [31:0] fault_addr;
  } ced_exc_t;

  typedef struct packed {
    logic valid;
    logic crit;
    logic [31:0] pc;
  } ced_redir_t;

  // ==========================================================
  // Vector offsets
  function automatic logic [15:0] vec_off(input logic [SW-1:0] s);
    case (s)
      5'h00, 5'h02: vec_off = 16'h0200;
      5'h01, 5'h03, 5'h0E: vec_off = 16'h2000;
      5'h04: vec_off = 16'h0100;
      5'h05: vec_off = 16'h1020;
      5'h06: vec_off = 16'h1200;
      5'h07, 5'h08: vec_off = 16'h0400;
      5'h09: vec_off = 16'h0700;
      5'h0A: vec_off = 16'h0C00;
      5'h0B: vec_off = 16'h1100;
      5'h0C: vec_off = 16'h0300;
      5'h0D: vec_off = 16'h0600;
      5'h0F: vec_off = 16'h0500;
      5'h10: vec_off = 16'h1010;
      default: vec_off = 16'h1000;
    endcase
  endfunction

  // Byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (d & m);
  endfunction

endpackage

// [ced_prio.sv]
// Fixed-priority selector over the exception sources
`timescale 1ns/1ns
module ced_prio
  import ced_pkg::*;
(
  // Requests, bit 0 highest
  input wire logic [NSRC-1:0] req,
  // Selection
  output logic [NSRC-1:0] grant,
  output logic [SW-1:0] idx,
  output logic any
);

  // ==========================================================
  // Priority chain
  logic [NSRC:0] seen;
  assign seen[0] = 1'b0;

  for (genvar i = 0; i < NSRC; i++) begin : g_bit
    assign grant[i] = req[i] & ~seen[i];
    assign seen[i+1] = seen[i] | req[i];
  end

  assign any = seen[NSRC];

  // ==========================================================
  // Index encode
  always_comb begin
    idx = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (grant[i]) begin
        idx = SW'(i);
      end
    end
  end

endmodule

// [ced_core.sv]
// Exception dispatch and return unit with its register file
// Function
// - Critical: critical input, bus-error machine checks, watchdog, debug; others noncritical.
// - Critical before noncritical, except low-priority debug events.
// - Entry saves return address in critical or noncritical return register.
// - Entry copies machine state to critical or noncritical saved-state register.
// - Critical entry never overwrites noncritical saved pair.
// - Return address is excepting or next instruction, per exception.
// - Syndrome updated only for machine check, storage, program, data TLB miss.
// - Fault address updated only for data storage, alignment, data TLB miss.
// - Entry forces privileged real mode and masks interrupts per exception.
// - Entry is context synchronizing under the new machine state.
// - Handler address is 64KB-aligned prefix base plus vector offset.
// - Both returns privileged; each serves its own handler class.
// - Return waits until earlier instructions completed and cannot except.
// - Noncritical return restores state, synchronizes, fetches noncritical return address.
// - Exceptions taken one at a time in fixed order.
// - Enabled lower-priority interrupt goes before masked higher-priority one.
// - Priorities one to six: data check, address compare, fetch check, debug, input, watchdog.
// - Then instruction TLB miss, no-access, non-executable or guarded storage.
// - Offsets 0x0100 critical input, 0x1020 watchdog, 0x2000 debug.
// - Lowest: external input, fixed-interval timer, programmable-interval timer.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module ced_core
  import ced_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Exception requests
  input wire ced_exc_t exc_in,
  input wire logic crit_irq_pin,
  input wire logic ext_irq_pin,
  // Return instructions
  input wire logic ret_req,
  input wire logic ret_crit,
  input wire logic pipe_drained,
  // Pipeline control
  output logic [NSRC-1:0] exc_ack,
  output ced_redir_t redirect,
  output logic [31:0] msr_out,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // State
  ced_state_t state_r, state_nxt;
  logic crit_s1_r, crit_s2_r, ext_s1_r, ext_s2_r;
  logic priv_pend_r, retc_r, last_crit_r;
  logic [SW-1:0] last_src_r;
  logic [31:0] msr_r, vpb_r, ncrit_ret_r, ncrit_state_r;
  logic [31:0] crit_ret_r, crit_state_r, esr_r, dfa_r;
  logic [NSRC-1:0] ack_r;
  ced_redir_t redir_r;
  logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crit_s1_r <= 1'b0;
      crit_s2_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      crit_s1_r <= crit_irq_pin;
      crit_s2_r <= crit_s1_r;
      ext_s1_r <= ext_irq_pin;
      ext_s2_r <= ext_s1_r;
    end
  end

  // ==========================================================
  // Pending, enable and selection
  wire [NSRC-1:0] one = {{(NSRC-1){1'b0}}, 1'b1};
  wire [NSRC-1:0] pin_bits = (one << S_CIN) | (one << S_EXT);
  wire [NSRC-1:0] pin_req = ({{(NSRC-1){1'b0}}, crit_s2_r} << S_CIN)
                          | ({{(NSRC-1){1'b0}}, ext_s2_r} << S_EXT);
  wire [NSRC-1:0] priv_req = {{(NSRC-1){1'b0}}, priv_pend_r} << S_PROG;
  wire [NSRC-1:0] req_all = (exc_in.req & ~pin_bits) | pin_req | priv_req;
  wire [NSRC-1:0] en_mask = ~((ME_MASK & {NSRC{~msr_r[MSR_ME]}})
                            | (DE_MASK & {NSRC{~msr_r[MSR_DE]}})
                            | (CE_MASK & {NSRC{~msr_r[MSR_CE]}})
                            | (EE_MASK & {NSRC{~msr_r[MSR_EE]}}));
  wire [NSRC-1:0] live = req_all & en_mask;
  logic [NSRC-1:0] grant;
  logic [SW-1:0] sel;
  logic any_en;

  ced_prio u_prio (
    .req(live),
    .grant(grant),
    .idx(sel),
    .any(any_en)
  );

  wire take = any_en && (state_r != ST_SYNC);
  wire sel_crit = |(grant & CRIT_MASK);
  wire sel_esr = |(grant & ESR_MASK);
  wire sel_dfa = |(grant & DATA_FAULT_ADDRESS_REG_MASK);
  wire sel_next = |(grant & NEXT_MASK);
  wire sel_mchk = |(grant & ME_MASK);
  wire [31:0] ret_pc = sel_next ? exc_in.next_pc : exc_in.cur_pc;
  wire [31:0] vec_pc = (vpb_r & VPB_MASK) + {16'h0000, vec_off(sel)};
  wire [31:0] msr_clr = MSR_CLR_ALL | (sel_crit ? MSR_CLR_CRIT : REG_RST)
                      | (sel_mchk ? MSR_CLR_MCHK : REG_RST);
  wire [31:0] new_msr = msr_r & ~msr_clr;
  wire [31:0] esr_in = exc_in.syndrome | ((priv_pend_r && grant[S_PROG]) ? ESR_PPR : REG_RST);

  // ==========================================================
  // Return instructions
  wire idle_ret = (state_r == ST_IDLE) && ret_req && !any_en;
  wire priv_fault = idle_ret && msr_r[MSR_PR];
  wire ret_start = idle_ret && !msr_r[MSR_PR];
  wire ret_go = (state_r == ST_RWAIT) && pipe_drained && !any_en;
  wire [31:0] ret_msr = retc_r ? crit_state_r : ncrit_state_r;
  wire [31:0] ret_tgt = retc_r ? crit_ret_r : ncrit_ret_r;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_SYNC;
        end else if (ret_start) begin
          state_nxt = ST_RWAIT;
        end
      end
      ST_RWAIT: begin
        if (take || ret_go) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      retc_r <= 1'b0;
      priv_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (ret_start) begin
        retc_r <= ret_crit;
      end
      if (priv_fault) begin
        priv_pend_r <= 1'b1;
      end else if (take && grant[S_PROG]) begin
        priv_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Pipeline outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r <= '0;
      redir_r <= '0;
      last_src_r <= '0;
      last_crit_r <= 1'b0;
    end else begin
      ack_r <= take ? grant : '0;
      redir_r.valid <= take || ret_go;
      redir_r.crit <= take ? sel_crit : retc_r;
      redir_r.pc <= take ? vec_pc : ret_tgt;
      if (take) begin
        last_src_r <= sel;
        last_crit_r <= sel_crit;
      end
    end
  end

  // ==========================================================
  // Bus write channel
  wire aw_fire = s_axi_awvalid && awready_r;
  wire w_fire = s_axi_wvalid && wready_r;
  wire wr_do = aw_full_r && w_full_r && !bvalid_r;
  wire aw_full_nxt = !wr_do && (aw_full_r || aw_fire);
  wire w_full_nxt = !wr_do && (w_full_r || w_fire);
  wire wr_msr = wr_do && (awaddr_r == A_MSR);
  wire wr_vpb = wr_do && (awaddr_r == A_VPB);
  wire wr_nra = wr_do && (awaddr_r == A_NRA);
  wire wr_nss = wr_do && (awaddr_r == A_NSS);
  wire wr_cra = wr_do && (awaddr_r == A_CRA);
  wire wr_css = wr_do && (awaddr_r == A_CSS);
  wire wr_esr = wr_do && (awaddr_r == A_ESR);
  wire wr_dfa = wr_do && (awaddr_r == A_DFA);
  wire wr_hit = wr_msr || wr_vpb || wr_nra || wr_nss || wr_cra || wr_css
              || wr_esr || wr_dfa;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= REG_RST;
      wstrb_r <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= !aw_full_nxt;
      wready_r <= !w_full_nxt;
      if (aw_fire) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Architected registers, hardware update wins over software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msr_r <= MSR_RST;
      vpb_r <= REG_RST;
    end else begin
      if (take) begin
        msr_r <= new_msr;
      end else if (ret_go) begin
        msr_r <= ret_msr;
      end else if (wr_msr) begin
        msr_r <= merge(msr_r, wdata_r, wstrb_r);
      end
      if (wr_vpb) begin
        vpb_r <= merge(vpb_r, wdata_r, wstrb_r) & VPB_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ncrit_ret_r <= REG_RST;
      ncrit_state_r <= REG_RST;
    end else begin
      if (take && !sel_crit) begin
        ncrit_ret_r <= ret_pc;
        ncrit_state_r <= msr_r;
      end else begin
        if (wr_nra) begin
          ncrit_ret_r <= merge(ncrit_ret_r, wdata_r, wstrb_r);
        end
        if (wr_nss) begin
          ncrit_state_r <= merge(ncrit_state_r, wdata_r, wstrb_r);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crit_ret_r <= REG_RST;
      crit_state_r <= REG_RST;
    end else begin
      if (take && sel_crit) begin
        crit_ret_r <= ret_pc;
        crit_state_r <= msr_r;
      end else begin
        if (wr_cra) begin
          crit_ret_r <= merge(crit_ret_r, wdata_r, wstrb_r);
        end
        if (wr_css) begin
          crit_state_r <= merge(crit_state_r, wdata_r, wstrb_r);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      esr_r <= REG_RST;
      dfa_r <= REG_RST;
    end else begin
      if (take && sel_esr) begin
        esr_r <= esr_in;
      end else if (wr_esr) begin
        esr_r <= merge(esr_r, wdata_r, wstrb_r);
      end
      if (take && sel_dfa) begin
        dfa_r <= exc_in.fault_addr;
      end else if (wr_dfa) begin
        dfa_r <= merge(dfa_r, wdata_r, wstrb_r);
      end
    end
  end

  // ==========================================================
  // Bus read channel
  wire ar_fire = s_axi_arvalid && arready_r;
  wire rvalid_nxt = ar_fire || (rvalid_r && !s_axi_rready);
  wire [31:0] stat_val = {25'h0000000, last_crit_r, state_r == ST_RWAIT, last_src_r};
  logic [31:0] rd_val;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      A_MSR: rd_val = msr_r;
      A_VPB: rd_val = vpb_r;
      A_NRA: rd_val = ncrit_ret_r;
      A_NSS: rd_val = ncrit_state_r;
      A_CRA: rd_val = crit_ret_r;
      A_CSS: rd_val = crit_state_r;
      A_ESR: rd_val = esr_r;
      A_DFA: rd_val = dfa_r;
      A_STAT: rd_val = stat_val;
      default: begin
        rd_val = REG_RST;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= REG_RST;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_fire) begin
        rdata_r <= rd_val;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Output assignments
  assign exc_ack = ack_r;
  assign redirect = redir_r;
  assign msr_out = msr_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_take_crit;
    take && sel_crit && !wr_do;
  endsequence

  sequence s_ret_noncrit;
    ret_go && !retc_r;
  endsequence

  sequence s_sync_then_idle;
    (state_r == ST_SYNC) ##1 (state_r == ST_IDLE);
  endsequence

  AST_CRIT_PAIR: assert property (s_take_crit |=>
    crit_ret_r == $past(ret_pc) && $stable(ncrit_ret_r) && $stable(ncrit_state_r))
    else $error("critical entry disturbed the noncritical pair");

  AST_STATE_SAVE: assert property (take && !sel_crit |=>
    ncrit_state_r == $past(msr_r) && redirect.crit == 1'b0)
    else $error("noncritical entry did not save machine state");

  AST_ESR_HOLD: assert property (take && !sel_esr && !wr_esr |=> $stable(esr_r))
    else $error("syndrome changed for an exception that does not report it");

  AST_DFA_HOLD: assert property (take && !sel_dfa && !wr_dfa |=> $stable(dfa_r))
    else $error("fault address changed for an exception that does not report it");

  AST_NEW_MSR: assert property (take |=>
    !msr_r[MSR_PR] && !msr_r[MSR_EE] && (msr_r & MSR_CLR_ALL) == REG_RST)
    else $error("entry left user mode, translation or external enable on");

  AST_VECTOR: assert property (take |=> redirect.valid &&
    redirect.pc == ($past(vpb_r) & VPB_MASK) + {16'h0000, vec_off($past(sel))})
    else $error("handler address is not base plus vector offset");

  AST_SERIAL: assert property (take |=> !take ##0 s_sync_then_idle)
    else $error("two exceptions taken without a synchronising cycle");

  AST_PRIO: assert property (take |-> (live & NSRC'(grant - one)) == '0)
    else $error("a higher-priority enabled exception was passed over");

  AST_MASKED: assert property (take |-> (grant & ~en_mask) == '0 && $onehot(grant))
    else $error("a masked exception was taken");

  AST_RET_WAIT: assert property ((state_r == ST_RWAIT) && !pipe_drained |=>
    !redirect.valid || $past(take))
    else $error("return redirected before the pipeline drained");

  AST_RFI: assert property (s_ret_noncrit |=>
    msr_r == $past(ncrit_state_r) && redirect.pc == $past(ncrit_ret_r))
    else $error("noncritical return restored the wrong pair");

  AST_RFCI: assert property (ret_go && retc_r |=>
    msr_r == $past(crit_state_r) && redirect.pc == $past(crit_ret_r) && redirect.crit)
    else $error("critical return restored the wrong pair");

  AST_PRIV: assert property (priv_fault |=> priv_pend_r ##0 (state_r == ST_IDLE))
    else $error("user-mode return was not refused");

endmodule

// [ced_pipe.sv]
// Pipeline-side model: holds exception requests until acknowledged
`timescale 1ns/1ns
module ced_pipe
  import ced_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request control
  input wire logic [NSRC-1:0] set_req,
  input wire logic [NSRC-1:0] exc_ack,
  output logic [NSRC-1:0] req
);
  // ==========================================================
  // Request drops after its acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= '0;
    end else begin
      req <= (req & ~exc_ack) | set_req;
    end
  end
endmodule

// [testbench.sv]
// Self-checking testbench of the exception dispatch unit
`timescale 1ns/1ns
module testbench;
  import ced_pkg::*;
  logic aclk, aresetn, ret_req, ret_crit, pipe_drained, crit_irq_pin, ext_irq_pin;
  logic [NSRC-1:0] set_req, exc_ack, req;
  logic [31:0] cpc, npc, syn, fad, msr_out, s_axi_wdata, s_axi_rdata;
  ced_exc_t exc_in;
  ced_redir_t redirect;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count = 0;
  int comparisons = 0;
  assign exc_in = {req, cpc, npc, syn, fad};
  // ==========================================================
  // Design and pipeline model
  ced_core ced_core_i (.aclk, .aresetn, .exc_in, .crit_irq_pin, .ext_irq_pin, .ret_req,
    .ret_crit, .pipe_drained, .exc_ack, .redirect, .msr_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ced_pipe ced_pipe_i (.aclk, .aresetn, .set_req, .exc_ack, .req);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ==========================================================
  // Shared tasks
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (n >= 50) begin
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      test_done;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w) && n < 50) begin
      @(posedge aclk);
      n++;
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 50);
    chk(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task rck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask
  task ent(input logic [NSRC-1:0] m, input logic [NSRC-1:0] ack, input logic [31:0] pc);
    int n;
    n = 0;
    set_req <= m;
    do begin @(posedge aclk); set_req <= '0; n++; end while (redirect.valid !== 1'b1 && n < 50);
    tmo(n);
    chk(exc_ack, ack);
    chk(redirect.pc, pc);
  endtask
  task ret(input logic c, input logic [31:0] pc, input logic [31:0] m);
    int n;
    n = 0;
    ret_req <= 1'b1;
    ret_crit <= c;
    pipe_drained <= 1'b0;
    @(posedge aclk);
    ret_req <= 1'b0;
    repeat (4) begin @(posedge aclk); chk(redirect.valid, 0); end
    pipe_drained <= 1'b1;
    do begin @(posedge aclk); n++; end while (redirect.valid !== 1'b1 && n < 50);
    tmo(n);
    chk(redirect.pc, pc);
    chk(msr_out, m);
    chk(redirect.crit, c);
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rck(A_MSR, 32'h00000000);
    wr(A_VPB, 32'h12345678);
    rck(A_VPB, 32'h12340000);
    rd(8'h24, d, r);
    chk(r, RESP_SLVERR);
    wr(A_MSR, 32'h00029200);
    $display("registers done");
  endtask
  task t_entry;
    cpc <= 32'h00000100;
    npc <= 32'h00000104;
    syn <= 32'h00800000;
    fad <= 32'h00000ABC;
    ent(18'h00400, 18'h00400, 32'h12340C00);
    rck(A_NRA, 32'h00000104);
    rck(A_NSS, 32'h00029200);
    rck(A_ESR, 32'h00000000);
    rck(A_DFA, 32'h00000000);
    rck(A_MSR, 32'h00021200);
    cpc <= 32'h00000200;
    ent(18'h00020, 18'h00020, 32'h12341020);
    rck(A_CRA, 32'h00000200);
    rck(A_CSS, 32'h00021200);
    rck(A_NRA, 32'h00000104);
    rck(A_MSR, 32'h00001000);
    $display("entry done");
  endtask
  task t_ret;
    ret(1'b1, 32'h00000200, 32'h00021200);
    ret(1'b0, 32'h00000104, 32'h00029200);
    $display("return done");
  endtask
  task t_prio;
    ent(18'h02800, 18'h00800, 32'h12341100);
    ent(18'h00000, 18'h02000, 32'h12340600);
    rck(A_ESR, 32'h00800000);
    rck(A_DFA, 32'h00000ABC);
    crit_irq_pin <= 1'b1;
    ent(18'h00000, 18'h00010, 32'h12340100);
    crit_irq_pin <= 1'b0;
    wr(A_MSR, 32'h00020200);
    ent(18'h00041, 18'h00040, 32'h12341200);
    $display("priority done");
  endtask
  task t_priv;
    wr(A_MSR, 32'h0000C000);
    ret_req <= 1'b1;
    ret_crit <= 1'b0;
    @(posedge aclk);
    ret_req <= 1'b0;
    ent(18'h00000, 18'h00200, 32'h12340700);
    rck(A_ESR, 32'h08800000);
    rck(A_NSS, 32'h0000C000);
    $display("privilege done");
  endtask
  task t_ext;
    ext_irq_pin <= 1'b1;
    wr(A_MSR, 32'h00008000);
    ent(18'h00000, 18'h08000, 32'h12340500);
    ext_irq_pin <= 1'b0;
    rck(A_MSR, 32'h00000000);
    $display("external done");
  endtask
  initial begin
    aresetn = 1'b0;
    set_req = '0;
    ret_req = 1'b0;
    ret_crit = 1'b0;
    pipe_drained = 1'b1;
    crit_irq_pin = 1'b0;
    ext_irq_pin = 1'b0;
    {cpc, npc, syn, fad} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_entry;
    t_ret;
    t_prio;
    t_priv;
    t_ext;
    test_done;
  end
endmodule
